// File: shared/dlhs_pkg.sv
// constants and types for the debug link handshake and speed-probe logic
// assumes one system clock that stands in for the vco clock
package dlhs_pkg;
    // serial clock is the vco clock divided by eight
    localparam int unsigned SER_DIV = 8;
    localparam logic [2:0] SER_DIV_LAST = 3'(SER_DIV - 1);
    // all counts below are in serial clock ticks
    localparam logic [7:0] ACK_LOW_TICKS = 8'h10;
    localparam logic [7:0] ACK_MIN_TICKS = 8'h20;
    localparam logic [7:0] SYNC_REQ_TICKS = 8'h80;
    localparam logic [7:0] SYNC_DELAY_TICKS = 8'h10;
    localparam logic [7:0] SYNC_RESP_TICKS = 8'h80;
    localparam logic [7:0] SPEEDUP_TICKS = 8'h01;

    typedef enum logic [3:0] {
        CMD_ACK_ON = 4'h0,
        CMD_ACK_OFF = 4'h1,
        CMD_READ = 4'h2,
        CMD_WRITE = 4'h3,
        CMD_BACKGROUND = 4'h4,
        CMD_GO = 4'h5,
        CMD_GO_UNTIL = 4'h6,
        CMD_STEP = 4'h7,
        CMD_OTHER = 4'h8
    } dlhs_cmd_type;
endpackage

// File: src/dlhs_pin_pulse.sv
// open-drain pulse driver: low for a tick count, one speedup tick high, release
// assumes tick_in is a one-cycle serial clock tick
`timescale 1ns/1ps
module dlhs_pin_pulse (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic tick_in,
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic [7:0] low_len_in,
    output logic pin_out,
    output logic pin_oe_out,
    output logic busy_out,
    output logic done_out
);
    import dlhs_pkg::*;
    typedef enum logic [2:0] {
        PP_IDLE = 3'b001,
        PP_LOW = 3'b010,
        PP_HIGH = 3'b100
    } dlhs_pp_state_type;
    dlhs_pp_state_type state, next_state;
    logic [7:0] cnt, next_cnt, len, next_len;
    logic next_pin, next_oe, next_done;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_len = len;
        next_done = 1'b0;
        case (state)
            PP_IDLE: begin
                if (start_in) begin
                    next_state = PP_LOW;
                    next_cnt = 8'h00;
                    next_len = low_len_in;
                end
            end
            PP_LOW: begin
                if (tick_in) begin
                    if (cnt == 8'(len - 8'h01)) begin
                        next_state = PP_HIGH;
                        next_cnt = 8'h00;
                    end else begin
                        next_cnt = 8'(cnt + 8'h01);
                    end
                end
            end
            PP_HIGH: begin
                if (tick_in && cnt == 8'(SPEEDUP_TICKS - 8'h01)) begin
                    next_state = PP_IDLE;
                    next_done = 1'b1;
                end else if (tick_in) begin
                    next_cnt = 8'(cnt + 8'h01);
                end
            end
            default: next_state = PP_IDLE;
        endcase
        // a speed-probe request cuts any pulse short
        if (abort_in) begin
            next_state = PP_IDLE;
            next_done = 1'b0;
        end
        // only drive low or a short high, else released
        next_oe = (next_state != PP_IDLE);
        next_pin = (next_state == PP_HIGH);
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= PP_IDLE;
            cnt <= 8'h00;
            len <= 8'h00;
            pin_out <= 1'b0;
            pin_oe_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            len <= next_len;
            pin_out <= next_pin;
            pin_oe_out <= next_oe;
            done_out <= next_done;
        end
    end

    assign busy_out = (state != PP_IDLE);

    property p_pp_low_first;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(pin_oe_out) |-> !pin_out;
    endproperty
    a_pp_low_first: assert property (p_pp_low_first) else $error("pulse did not open low");
endmodule

// File: src/dlhs_tick_gen.sv
// serial clock tick generator: one-cycle tick every SER_DIV clocks
// assumes clk_in is the vco clock
`timescale 1ns/1ps
module dlhs_tick_gen (
    input wire logic clk_in,
    input wire logic resetn_in,
    output logic tick_out
);
    import dlhs_pkg::*;
    logic [2:0] cnt;
    logic [2:0] next_cnt;

    always_comb begin
        next_cnt = (cnt == SER_DIV_LAST) ? 3'h0 : 3'(cnt + 3'h1);
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt <= 3'h0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tick_out = (cnt == SER_DIV_LAST);
endmodule

// File: src/dlhs_top.sv
// handshake, speed-probe response and single-step control of the debug link
// assumes a command decoder that flags each fully received command
// Behaviour
// - handshake off after reset; speed-probe soft reset keeps it
// - handshake-on enables and acknowledges itself
// - handshake-off stops all later acknowledges until the next handshake-on
// - reads acknowledge after bus cycle, data ready
// - writes acknowledge after data and bus cycle
// - enter-debug acknowledges on entering background mode
// - resume acknowledges on leaving background mode
// - resume-until-halt acknowledges on next background entry
// - step acknowledges on re-entering background mode
// - speed-probe request cancels pending control acknowledges
// - serial clock is vco clock over eight
// - wait high, 16, low 128, speedup, release
// - speed-probe request soft-resets partial command
// - step runs exactly one user instruction
// - pending interrupt during step only stacks
// - stop/wait blocks enter-debug; system stop blocks all
// - step into stop/wait drops its acknowledge
// - system stop clears handshake enable
// - acknowledge is 16 ticks low plus speedup
// - acknowledge no sooner than 32 ticks after command
// - read time-out held until acknowledge issued
`timescale 1ns/1ps
module dlhs_top (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    input wire logic cmd_valid_in,
    input wire dlhs_pkg::dlhs_cmd_type cmd_class_in,
    input wire logic bus_done_in,
    input wire logic cpu_bdm_in,
    input wire logic stop_wait_in,
    input wire logic system_stop_in,
    input wire logic irq_pending_in,
    output logic ack_en_out,
    output logic soft_reset_out,
    output logic sync_busy_out,
    output logic timeout_hold_out,
    output logic step_go_out,
    output logic step_irq_only_out
);
    import dlhs_pkg::*;

    typedef enum logic [4:0] {
        SY_IDLE = 5'b00001,
        SY_LOW = 5'b00010,
        SY_WAIT_HIGH = 5'b00100,
        SY_DELAY = 5'b01000,
        SY_RESP = 5'b10000
    } dlhs_sy_state_type;
    typedef enum logic [2:0] {
        AK_IDLE = 3'b001,
        AK_WAIT = 3'b010,
        AK_SEND = 3'b100
    } dlhs_ak_state_type;

    logic tick, drv_busy, drv_done, drv_oe, drv_pin;
    dlhs_sy_state_type sy_state, next_sy_state;
    dlhs_ak_state_type ak_state, next_ak_state;
    dlhs_cmd_type kind, next_kind;
    logic [7:0] sy_cnt, next_sy_cnt, min_cnt, next_min_cnt;
    logic sync_detect, resp_start, ack_start, cmd_take;
    logic ack_en, next_ack_en, evt, next_evt, bdm_q, sw_q;
    logic next_step_go, next_step_irq, bdm_rise, bdm_fall, sw_rise, evt_now;

    // serial clock derived from the vco clock
    dlhs_tick_gen u_tick (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .tick_out(tick)
    );

    dlhs_pin_pulse u_pulse (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .tick_in(tick),
        .start_in(ack_start | resp_start),
        .abort_in(sync_detect),
        .low_len_in(resp_start ? SYNC_RESP_TICKS : ACK_LOW_TICKS),
        .pin_out(drv_pin),
        .pin_oe_out(drv_oe),
        .busy_out(drv_busy),
        .done_out(drv_done)
    );
    assign pin_out = drv_pin;
    assign pin_oe_out = drv_oe;

    // speed-probe detection and response
    always_comb begin
        next_sy_state = sy_state;
        next_sy_cnt = sy_cnt;
        sync_detect = 1'b0;
        resp_start = 1'b0;
        case (sy_state)
            SY_IDLE: begin
                // our own pulse must not look like a request
                if (!pin_in && !drv_oe) begin
                    next_sy_state = SY_LOW;
                    next_sy_cnt = 8'h00;
                end
            end
            SY_LOW: begin
                if (pin_in) begin
                    next_sy_state = SY_IDLE;
                end else if (tick) begin
                    if (sy_cnt == 8'(SYNC_REQ_TICKS - 8'h01)) begin
                        sync_detect = 1'b1;
                        next_sy_state = SY_WAIT_HIGH;
                    end else begin
                        next_sy_cnt = 8'(sy_cnt + 8'h01);
                    end
                end
            end
            SY_WAIT_HIGH: begin
                // no time-out: the probe must eventually release
                if (pin_in) begin
                    next_sy_state = SY_DELAY;
                    next_sy_cnt = 8'h00;
                end
            end
            SY_DELAY: begin
                if (tick) begin
                    if (sy_cnt == 8'(SYNC_DELAY_TICKS - 8'h01)) begin
                        resp_start = 1'b1;
                        next_sy_state = SY_RESP;
                    end else begin
                        next_sy_cnt = 8'(sy_cnt + 8'h01);
                    end
                end
            end
            SY_RESP: begin
                if (drv_done) begin
                    next_sy_state = SY_IDLE;
                end
            end
            default: next_sy_state = SY_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sy_state <= SY_IDLE;
            sy_cnt <= 8'h00;
        end else begin
            sy_state <= next_sy_state;
            sy_cnt <= next_sy_cnt;
        end
    end

    // command acceptance and acknowledge scheduling
    assign bdm_rise = cpu_bdm_in && !bdm_q;
    assign bdm_fall = !cpu_bdm_in && bdm_q;
    assign sw_rise = stop_wait_in && !sw_q;
    assign cmd_take = cmd_valid_in && !system_stop_in
        && !(stop_wait_in && cmd_class_in == CMD_BACKGROUND);

    always_comb begin
        next_ak_state = ak_state;
        next_kind = kind;
        next_evt = evt;
        next_min_cnt = min_cnt;
        next_ack_en = ack_en;
        next_step_go = 1'b0;
        next_step_irq = step_irq_only_out;
        ack_start = 1'b0;
        evt_now = 1'b0;
        case (kind)
            CMD_READ: evt_now = bus_done_in;
            CMD_WRITE: evt_now = bus_done_in;
            CMD_BACKGROUND: evt_now = bdm_rise;
            CMD_GO: evt_now = bdm_fall;
            CMD_GO_UNTIL: evt_now = bdm_rise;
            CMD_STEP: evt_now = bdm_rise;
            default: evt_now = 1'b0;
        endcase
        case (ak_state)
            AK_IDLE: begin
            end
            AK_WAIT: begin
                if (tick && min_cnt != ACK_MIN_TICKS) begin
                    next_min_cnt = 8'(min_cnt + 8'h01);
                end
                if (evt_now) begin
                    next_evt = 1'b1;
                end
                if (kind == CMD_STEP && sw_rise) begin
                    next_ak_state = AK_IDLE;
                // start on a tick so the low phase is whole ticks
                end else if (tick && evt && min_cnt == ACK_MIN_TICKS
                        && sy_state == SY_IDLE && !drv_busy) begin
                    ack_start = 1'b1;
                    next_ak_state = AK_SEND;
                end
            end
            AK_SEND: begin
                if (drv_done) begin
                    next_ak_state = AK_IDLE;
                end
            end
            default: next_ak_state = AK_IDLE;
        endcase
        // commands are dropped in system stop, and enter-debug in stop/wait; all others are taken
        if (cmd_take) begin
            next_kind = cmd_class_in;
            next_min_cnt = 8'h00;
            next_evt = 1'b0;
            next_ak_state = AK_IDLE;
            if (cmd_class_in == CMD_ACK_ON) begin
                next_ack_en = 1'b1;
                next_evt = 1'b1;
                next_ak_state = AK_WAIT;
            end else if (cmd_class_in == CMD_ACK_OFF) begin
                next_ack_en = 1'b0;
            end else if (cmd_class_in != CMD_OTHER && ack_en) begin
                next_ak_state = AK_WAIT;
            end
            if (cmd_class_in == CMD_STEP) begin
                // one instruction, or stacking only if an interrupt waits
                next_step_go = 1'b1;
                next_step_irq = irq_pending_in;
            end
        end
        if (sync_detect) begin
            next_ak_state = AK_IDLE;
            next_evt = 1'b0;
        end
        if (system_stop_in) begin
            next_ack_en = 1'b0;
            next_ak_state = AK_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ak_state <= AK_IDLE;
            kind <= CMD_OTHER;
            evt <= 1'b0;
            min_cnt <= 8'h00;
            ack_en <= 1'b0;
            bdm_q <= 1'b0;
            sw_q <= 1'b0;
            step_go_out <= 1'b0;
            step_irq_only_out <= 1'b0;
            soft_reset_out <= 1'b0;
        end else begin
            ak_state <= next_ak_state;
            kind <= next_kind;
            evt <= next_evt;
            min_cnt <= next_min_cnt;
            ack_en <= next_ack_en;
            bdm_q <= cpu_bdm_in;
            sw_q <= stop_wait_in;
            step_go_out <= next_step_go;
            step_irq_only_out <= next_step_irq;
            soft_reset_out <= sync_detect;
        end
    end

    assign ack_en_out = ack_en;
    assign sync_busy_out = (sy_state != SY_IDLE);
    // read time-out suspended until the acknowledge goes out
    assign timeout_hold_out = (ak_state == AK_WAIT) && (kind == CMD_READ);

    property p_ack_on_only_by_cmd;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(ack_en) |-> $past(cmd_take) && $past(cmd_class_in) == CMD_ACK_ON;
    endproperty
    a_ack_on_only_by_cmd: assert property (p_ack_on_only_by_cmd) else $error("enable set without command");

    property p_ack_off;
        @(posedge clk_in) disable iff (!resetn_in)
        cmd_take && cmd_class_in == CMD_ACK_OFF |=> !ack_en && ak_state == AK_IDLE;
    endproperty
    a_ack_off: assert property (p_ack_off) else $error("handshake not turned off");

    property p_sys_stop;
        @(posedge clk_in) disable iff (!resetn_in)
        system_stop_in |=> !ack_en && ak_state == AK_IDLE;
    endproperty
    a_sys_stop: assert property (p_sys_stop) else $error("system stop kept handshake");

    property p_sync_cancel;
        @(posedge clk_in) disable iff (!resetn_in)
        sync_detect |=> ak_state == AK_IDLE && soft_reset_out ##1 !soft_reset_out;
    endproperty
    a_sync_cancel: assert property (p_sync_cancel) else $error("ack survived speed probe");

    property p_ack_min_gap;
        @(posedge clk_in) disable iff (!resetn_in)
        ack_start |-> min_cnt == ACK_MIN_TICKS && evt && tick;
    endproperty
    a_ack_min_gap: assert property (p_ack_min_gap) else $error("ack started too early");

    property p_ack_shape;
        @(posedge clk_in) disable iff (!resetn_in)
        ack_start |=> pin_oe_out && !pin_out ##127 pin_oe_out && !pin_out
            ##1 pin_oe_out && pin_out;
    endproperty
    a_ack_shape: assert property (p_ack_shape) else $error("ack low phase too short");

    property p_resp_start;
        @(posedge clk_in) disable iff (!resetn_in)
        resp_start |-> pin_in && sy_cnt == 8'(SYNC_DELAY_TICKS - 8'h01) && tick;
    endproperty
    a_resp_start: assert property (p_resp_start) else $error("response started badly");

    property p_step_drop;
        @(posedge clk_in) disable iff (!resetn_in)
        ak_state == AK_WAIT && kind == CMD_STEP && sw_rise && !cmd_take
            |=> ak_state == AK_IDLE;
    endproperty
    a_step_drop: assert property (p_step_drop) else $error("step ack kept in stop");

    property p_hold_read;
        @(posedge clk_in) disable iff (!resetn_in)
        timeout_hold_out |-> $past(ack_en) || ack_en;
    endproperty
    a_hold_read: assert property (p_hold_read) else $error("hold without handshake");
endmodule

// File: verification/dlhs_probe_model.sv
// debug probe model on the open-drain debug pin: speed-probe request, reply timing
// assumes pin_in is the resolved wire level, pulled up when nobody drives low
`timescale 1ns/1ps
module dlhs_probe_model (
    input wire logic clk_in,
    input wire logic pin_in,
    input wire logic req_in,
    input wire logic [11:0] low_len_in,
    output logic drive_low_out,
    output logic drive_high_out,
    output logic busy_out,
    output logic [11:0] meas_low_out
);
    logic [11:0] cnt;
    initial begin
        drive_low_out = 1'b0;
        drive_high_out = 1'b0;
        busy_out = 1'b0;
        meas_low_out = 12'h000;
        cnt = 12'h000;
    end
    // long low, one-clock speedup, then release and listen
    always begin
        @(posedge clk_in iff req_in);
        busy_out = 1'b1;
        #1 drive_low_out = 1'b1;
        repeat (low_len_in) @(posedge clk_in);
        #1 drive_low_out = 1'b0;
        drive_high_out = 1'b1;
        @(posedge clk_in);
        #1 drive_high_out = 1'b0;
        busy_out = 1'b0;
    end
    // own drive excluded, so only the target's low is timed
    always @(posedge clk_in) begin
        if (!pin_in && !drive_low_out) begin
            cnt <= cnt + 12'h001;
        end else if (cnt != 12'h000) begin
            meas_low_out <= cnt;
            cnt <= 12'h000;
        end
    end
endmodule

// File: verification/tb_dlhs_top.sv
// self-checking bench for the debug link handshake, speed probe and step control
// assumes the probe model on the pin and a pull-up on the resolved wire
`timescale 1ns/1ps
module tb_dlhs_top;
    import dlhs_pkg::*;
    typedef struct {dlhs_cmd_type cls; int ev; int at; logic ack; logic en;} dlhs_row_type;
    logic clk_in = 0, resetn_in = 0, cmd_valid_in = 0, bus_done_in = 0, cpu_bdm_in = 0;
    logic stop_wait_in = 0, system_stop_in = 0, irq_pending_in = 0, req = 0;
    dlhs_cmd_type cmd_class_in = CMD_OTHER;
    logic pin_out, pin_oe_out, ack_en_out, soft_reset_out, sync_busy_out, timeout_hold_out;
    logic step_go_out, step_irq_only_out, p_low, p_high, p_busy;
    logic [11:0] p_meas;
    logic [11:0] req_len = 12'h410;
    int err_count = 0, n_checks = 0, sr_count = 0, sg_count = 0, lo, hi, k, s, n_clash = 0;
    // open drain: any low drive wins, otherwise the pull-up
    wire pin_in = !((pin_oe_out && !pin_out) || p_low);
    // ev: 1 bus cycle done, 2 background entry, 3 background exit, at clocks after take
    dlhs_row_type rows[12] = '{
        '{CMD_ACK_ON, 0, 0, 1, 1}, '{CMD_READ, 1, 10, 1, 1}, '{CMD_WRITE, 1, 400, 1, 1},
        '{CMD_BACKGROUND, 2, 20, 1, 1}, '{CMD_GO, 3, 300, 1, 1}, '{CMD_GO_UNTIL, 2, 500, 1, 1},
        '{CMD_STEP, 2, 30, 1, 1}, '{CMD_OTHER, 0, 0, 0, 1}, '{CMD_ACK_OFF, 0, 0, 0, 0},
        '{CMD_READ, 1, 10, 0, 0}, '{CMD_GO, 3, 10, 0, 0}, '{CMD_ACK_ON, 0, 0, 1, 1}};

    dlhs_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_out(pin_oe_out), .cmd_valid_in(cmd_valid_in), .cmd_class_in(cmd_class_in),
        .bus_done_in(bus_done_in), .cpu_bdm_in(cpu_bdm_in), .stop_wait_in(stop_wait_in),
        .system_stop_in(system_stop_in), .irq_pending_in(irq_pending_in),
        .ack_en_out(ack_en_out), .soft_reset_out(soft_reset_out),
        .sync_busy_out(sync_busy_out), .timeout_hold_out(timeout_hold_out),
        .step_go_out(step_go_out), .step_irq_only_out(step_irq_only_out));
    dlhs_probe_model probe (.clk_in(clk_in), .pin_in(pin_in), .req_in(req),
        .low_len_in(req_len), .drive_low_out(p_low), .drive_high_out(p_high),
        .busy_out(p_busy), .meas_low_out(p_meas));

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (soft_reset_out === 1'b1) sr_count++;
        if (step_go_out === 1'b1) sg_count++;
        // probe speedup must never meet a target drive
        if (p_high === 1'b1 && pin_oe_out === 1'b1) n_clash++;
    end

    task tick;
        @(posedge clk_in);
        #1;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task hang(input string what);
        check(what, 0, 1);
        give_verdict();
    endtask
    task send(input dlhs_cmd_type c);
        cmd_valid_in = 1;
        cmd_class_in = c;
        tick();
        cmd_valid_in = 0;
    endtask
    task wait_oe(input int bound);
        k = 0;
        while (pin_oe_out !== 1'b1 && k < bound) begin
            tick();
            k++;
        end
    endtask
    // called with the drive just started: low length, then speedup of one tick
    task shape(input int exp_lo);
        lo = 0;
        hi = 0;
        while (pin_oe_out === 1'b1 && pin_out === 1'b0 && lo < 1100) begin
            tick();
            lo++;
        end
        while (pin_oe_out === 1'b1 && pin_out === 1'b1 && hi < 20) begin
            tick();
            hi++;
        end
        check("low_len", lo, exp_lo);
        check("speedup_len", hi, SER_DIV);
        repeat (4) tick();
    endtask
    task run_row(input dlhs_row_type r);
        cpu_bdm_in = (r.ev == 3);
        send(r.cls);
        k = 0;
        // no-ack rows sit out a worst-case wait instead
        while (pin_oe_out !== 1'b1 && k < 900) begin
            bus_done_in = (r.ev == 1 && k == r.at);
            if (k == r.at && r.ev > 1) cpu_bdm_in = !cpu_bdm_in;
            if (k == 5 && r.cls == CMD_READ) check("hold", timeout_hold_out, r.en);
            tick();
            k++;
        end
        bus_done_in = 0;
        check("ack_en", ack_en_out, r.en);
        check("ack_seen", pin_oe_out === 1'b1, r.ack);
        if (r.cls == CMD_STEP) check("irq_only", step_irq_only_out, irq_pending_in);
        if (r.ack) begin
            check("ack_time", k >= 257 && k > r.at, 1);
            shape(128);
            if (r.cls == CMD_READ) check("hold_end", timeout_hold_out, 0);
        end
    endtask
    task do_sync;
        s = sr_count;
        req = 1;
        tick();
        req = 0;
        k = 0;
        while (p_busy === 1'b1 && k < 2000) begin
            tick();
            k++;
        end
        check("sync_busy", sync_busy_out, 1);
        wait_oe(300);
        if (pin_oe_out !== 1'b1) hang("sync_reply");
        check("sync_delay", k >= 118 && k <= 140, 1);
        shape(1024);
        check("soft_reset", sr_count - s, 1);
        check("probe_rate", p_meas, 1024);
        check("sync_idle", sync_busy_out, 0);
    endtask

    initial begin
        repeat (2) @(posedge clk_in);
        #1 resetn_in = 1;
        check("rst_en", ack_en_out, 0);
        check("rst_oe", pin_oe_out, 0);
        foreach (rows[i]) run_row(rows[i]);
        // pending ack of a control command is dropped by a speed probe
        cpu_bdm_in = 0;
        send(CMD_BACKGROUND);
        repeat (20) tick();
        do_sync();
        cpu_bdm_in = 1;
        wait_oe(600);
        check("cancel", pin_oe_out, 0);
        check("en_kept", ack_en_out, 1);
        // a low well short of the request length is only a bit
        s = sr_count;
        req_len = 12'h040;
        req = 1;
        tick();
        req = 0;
        wait_oe(200);
        check("short_low_reset", sr_count - s, 0);
        check("short_low_reply", pin_oe_out, 0);
        // known rate: request just over 128 ticks still detected
        req_len = 12'h408;
        do_sync();
        // step with interrupt pending, then into stop or wait
        irq_pending_in = 1;
        s = sg_count;
        send(CMD_STEP);
        cpu_bdm_in = 0;
        repeat (4) tick();
        check("step_go", sg_count - s, 1);
        check("irq_only", step_irq_only_out, 1);
        irq_pending_in = 0;
        stop_wait_in = 1;
        repeat (40) tick();
        stop_wait_in = 0;
        cpu_bdm_in = 1;
        wait_oe(600);
        check("step_drop", pin_oe_out, 0);
        stop_wait_in = 1;
        run_row(dlhs_row_type'{CMD_BACKGROUND, 2, 20, 0, 1});
        run_row(dlhs_row_type'{CMD_WRITE, 1, 20, 1, 1});
        stop_wait_in = 0;
        // full stop clears the handshake until it is switched on again
        system_stop_in = 1;
        repeat (3) tick();
        check("sys_stop_en", ack_en_out, 0);
        run_row(dlhs_row_type'{CMD_ACK_ON, 0, 0, 0, 0});
        system_stop_in = 0;
        run_row(dlhs_row_type'{CMD_ACK_ON, 0, 0, 1, 1});
        // reset in mid-run
        resetn_in = 0;
        repeat (2) tick();
        check("rerst_en", ack_en_out, 0);
        check("rerst_oe", pin_oe_out, 0);
        resetn_in = 1;
        repeat (2) tick();
        check("clash", n_clash, 0);
        give_verdict();
    end
endmodule
